/* core/mmc_cfg.svh */
`ifndef MMC_CFG_SVH
`define MMC_CFG_SVH
// Global map: 256 KByte, 18 address bits
`define MMC_GADDR_W      18
`define MMC_LADDR_W      16
`define MMC_PAGE_W       4
// Reset page index and fixed page numbers
`define MMC_PAGE_RST     4'he
`define MMC_PAGE_LO      4'hc
`define MMC_PAGE_MID     4'hd
`define MMC_PAGE_HI      4'hf
// Local window selector bits and paged window code
`define MMC_WIN_LO       2'h0
`define MMC_WIN_MID      2'h1
`define MMC_WIN_PAGED    2'h2
// Decode limits in the local map
`define MMC_REG_TOP      16'h03ff
`define MMC_RAM_BASE     16'h3000
`define MMC_FLASH_BASE   16'h4000
`define MMC_DFLASH_BASE  16'h0400
`define MMC_DFLASH_TOP   16'h13ff
// Global base of the program flash in the global map
`define MMC_GFLASH_BASE  18'h00000
`define MMC_DBG_ROM_BASE 16'hff00
`endif

/* core/mmc_decode.sv */
`timescale 1ns/1ps
`include "mmc_cfg.svh"
// ----------------------------------------
// Per-master address decoder
// ----------------------------------------
module mmc_decode #(
  parameter bit IS_DBG = 1'b0
) (
  input  wire logic [15:0]             laddr_i,
  input  wire logic [3:0]              page_i,
  input  wire logic                    secured_i,
  output mmc_pkg::mmc_tgt_t            tgt_o,
  output logic      [17:0]             gaddr_o,
  output logic                         deny_o
);
  logic [3:0] page;

  // Paging: top two local bits pick a fixed page or the paged window
  always_comb begin
    case (laddr_i[15:14])
      `MMC_WIN_LO:    page = `MMC_PAGE_LO;
      `MMC_WIN_MID:   page = `MMC_PAGE_MID;
      `MMC_WIN_PAGED: page = page_i;
      default:        page = `MMC_PAGE_HI;
    endcase
    gaddr_o = {page, laddr_i[13:0]};
  end

  // Map scheme differs per master: debug master also sees its own rom
  always_comb begin
    deny_o = 1'b0;
    if (IS_DBG && laddr_i >= `MMC_DBG_ROM_BASE) begin
      tgt_o = mmc_pkg::MMC_TGT_DBGROM;
    end else if (laddr_i <= `MMC_REG_TOP) begin
      tgt_o = mmc_pkg::MMC_TGT_REGS;
    end else if (laddr_i >= `MMC_DFLASH_BASE && laddr_i <= `MMC_DFLASH_TOP) begin
      tgt_o = mmc_pkg::MMC_TGT_DFLASH;
    end else if (laddr_i >= `MMC_RAM_BASE && laddr_i < `MMC_FLASH_BASE) begin
      tgt_o = mmc_pkg::MMC_TGT_RAM;
    end else if (laddr_i >= `MMC_FLASH_BASE) begin
      tgt_o = mmc_pkg::MMC_TGT_PFLASH;
      // Secured: the debug master may not read program flash
      deny_o = IS_DBG && secured_i;
    end else begin
      tgt_o = mmc_pkg::MMC_TGT_NONE;
    end
  end
endmodule : mmc_decode

/* core/mmc_pkg.sv */
package mmc_pkg;
  typedef enum logic [0:0] {
    MMC_NORMAL_SINGLE_CHIP  = 1'b0,
    MMC_SPECIAL_SINGLE_CHIP = 1'b1
  } mmc_mode_t;
  typedef enum logic [2:0] {
    MMC_TGT_NONE   = 3'b000,
    MMC_TGT_REGS   = 3'b001,
    MMC_TGT_RAM    = 3'b010,
    MMC_TGT_DFLASH = 3'b011,
    MMC_TGT_PFLASH = 3'b100,
    MMC_TGT_DBGROM = 3'b101
  } mmc_tgt_t;
  typedef enum logic [1:0] {
    MMC_ARB_IDLE = 2'b00,
    MMC_ARB_CPU  = 2'b01,
    MMC_ARB_DBG  = 2'b10
  } mmc_arb_t;
endpackage : mmc_pkg

/* core/mmc_top.sv */
// Overview of operation
// [R01] Capture mode pin at reset release
// [R02] Only normal and special single-chip modes
// [R03] Special mode forces debug-active after reset
// [R04] Processor unmapped access raises system reset
// [R05] Arbitrate processor and debug, one grant
// [R06] Paging reaches 256 KByte global space
// [R07] Separate address map per master
// [R08] Secured: block debug flash access; code blocks program flash only, debug still reaches data flash
// [R09] Mode bit loaded at release; pin before
// [R10] Illegal mode write: keep bit, lock
// [R11] Secured chip ignores mode writes
`timescale 1ns/1ps
`include "mmc_cfg.svh"
module mmc_top (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        mode_select_pin_i,
  input  wire logic        secured_i,
  input  wire logic        cpu_req_i,
  input  wire logic        cpu_we_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        dbg_req_i,
  input  wire logic [15:0] dbg_addr_i,
  input  wire logic        mode_wr_i,
  input  wire logic        mode_wdata_i,
  input  wire logic        page_wr_i,
  input  wire logic [3:0]  page_wdata_i,
  output logic             cpu_gnt_o,
  output logic             dbg_gnt_o,
  output logic [17:0]      mem_addr_o,
  output logic [2:0]       mem_tgt_o,
  output logic             mem_we_o,
  output logic             dbg_deny_o,
  output logic             sys_reset_req_o,
  output logic             mode_o,
  output logic [3:0]       page_o,
  output logic             background_debug_active_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic pin_s1, pin_s2, next_pin_s1, next_pin_s2;
  logic init, next_init;

  always_comb begin
    next_pin_s1 = mode_select_pin_i;
    next_pin_s2 = pin_s1;
    next_init   = 1'b0;
  end

  // Strap flops carry no reset: they keep tracking the pin while reset is
  // low, so the level seen at release has already passed both stages
  always_ff @(posedge mclk_i) begin
    pin_s1 <= next_pin_s1;
    pin_s2 <= next_pin_s2;
  end

  // Init marks the single load cycle right after release
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init   <= 1'b1;
    end else begin
      init   <= next_init;
    end
  end

  // ----------------------------------------
  // Mode control
  // ----------------------------------------
  // The pin is only a strap: the first clock after release loads the level
  // that stood two clocks earlier, so it must be steady across the release.
  mmc_pkg::mmc_mode_t mode, next_mode;
  logic               lock, next_lock;
  logic               legal;

  // Only special to normal is a legal change; staying put is harmless
  assign legal = (mode == mmc_pkg::MMC_SPECIAL_SINGLE_CHIP) || (mode_wdata_i == mode);

  always_comb begin
    next_mode = mode;
    next_lock = lock;
    if (init) begin
      next_mode = mmc_pkg::mmc_mode_t'(pin_s2);        // see [R01] see [R09]
      next_lock = 1'b0;
    end else if (mode_wr_i && !secured_i) begin        // see [R11]
      if (legal && !(lock && mode != mmc_pkg::MMC_SPECIAL_SINGLE_CHIP)) begin
        next_mode = mmc_pkg::mmc_mode_t'(mode_wdata_i); // see [R02]
      end else if (mode != mmc_pkg::MMC_SPECIAL_SINGLE_CHIP) begin
        next_lock = 1'b1;                               // see [R10]
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode <= mmc_pkg::MMC_NORMAL_SINGLE_CHIP;
      lock <= 1'b0;
    end else begin
      mode <= next_mode;
      lock <= next_lock;
    end
  end

  // While init is set the synchronised pin governs the mode
  assign mode_o = init ? pin_s2 : mode;                 // see [R09]

  // ----------------------------------------
  // Debug-active state
  // ----------------------------------------
  logic dbg_act, next_dbg_act;

  always_comb begin
    next_dbg_act = dbg_act;
    if (init) begin
      next_dbg_act = pin_s2;                           // see [R03]
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dbg_act <= 1'b0;
    end else begin
      dbg_act <= next_dbg_act;
    end
  end

  assign background_debug_active_o = dbg_act;

  // ----------------------------------------
  // Program page index
  // ----------------------------------------
  logic [3:0] page, next_page;

  always_comb begin
    next_page = page_wr_i ? page_wdata_i : page;       // see [R06]
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      page <= `MMC_PAGE_RST;
    end else begin
      page <= next_page;
    end
  end

  assign page_o = page;

  // ----------------------------------------
  // Decoders, one scheme per master
  // ----------------------------------------
  mmc_pkg::mmc_tgt_t cpu_tgt, dbg_tgt;
  logic [17:0]       cpu_gaddr, dbg_gaddr;
  logic              dbg_deny_c;

  mmc_decode #(.IS_DBG(1'b0)) u_dec_cpu (             // see [R07]
    .laddr_i   (cpu_addr_i),
    .page_i    (page),
    .secured_i (secured_i),
    .tgt_o     (cpu_tgt),
    .gaddr_o   (cpu_gaddr),
    .deny_o    ()
  );

  mmc_decode #(.IS_DBG(1'b1)) u_dec_dbg (             // see [R07]
    .laddr_i   (dbg_addr_i),
    .page_i    (page),
    .secured_i (secured_i),
    .tgt_o     (dbg_tgt),
    .gaddr_o   (dbg_gaddr),
    .deny_o    (dbg_deny_c)
  );

  // ----------------------------------------
  // Arbitration and access outputs
  // ----------------------------------------
  // Debug master wins a conflict: it steals cycles, which is cheap
  // because its traffic is sparse, and the processor only waits.
  mmc_pkg::mmc_arb_t owner;
  logic [17:0]       next_addr;
  logic [2:0]        next_tgt;
  logic              next_we, next_deny, next_rst;
  logic [17:0]       addr_q;
  logic [2:0]        tgt_q;
  logic              we_q, deny_q, rst_q;

  always_comb begin
    owner = mmc_pkg::MMC_ARB_IDLE;
    if (!init && dbg_req_i) begin
      owner = mmc_pkg::MMC_ARB_DBG;                    // see [R05]
    end else if (!init && cpu_req_i) begin
      owner = mmc_pkg::MMC_ARB_CPU;                    // see [R05]
    end
    next_addr = addr_q;
    next_tgt  = 3'h0;
    next_we   = 1'b0;
    next_deny = 1'b0;
    next_rst  = 1'b0;
    case (owner)
      mmc_pkg::MMC_ARB_CPU: begin
        next_addr = cpu_gaddr;                         // see [R06]
        next_tgt  = cpu_tgt;
        next_we   = cpu_we_i;
        next_rst  = (cpu_tgt == mmc_pkg::MMC_TGT_NONE); // see [R04]
      end
      mmc_pkg::MMC_ARB_DBG: begin
        next_addr = dbg_gaddr;
        next_deny = dbg_deny_c;                        // see [R08]
        next_tgt  = dbg_deny_c ? mmc_pkg::MMC_TGT_NONE : dbg_tgt; // see [R08]
      end
      default: begin
        next_addr = addr_q;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_q <= 18'h00000;
      tgt_q  <= 3'h0;
      we_q   <= 1'b0;
      deny_q <= 1'b0;
      rst_q  <= 1'b0;
    end else begin
      addr_q <= next_addr;
      tgt_q  <= next_tgt;
      we_q   <= next_we;
      deny_q <= next_deny;
      rst_q  <= next_rst;
    end
  end

  assign cpu_gnt_o       = (owner == mmc_pkg::MMC_ARB_CPU);
  assign dbg_gnt_o       = (owner == mmc_pkg::MMC_ARB_DBG);
  assign mem_addr_o      = addr_q;
  assign mem_tgt_o       = tgt_q;
  assign mem_we_o        = we_q;
  assign dbg_deny_o      = deny_q;
  assign sys_reset_req_o = rst_q;
endmodule : mmc_top

/* dv/memory_mode_control_tb.sv */
`timescale 1ns/1ps
module memory_mode_control_tb;
  logic        mclk_i, reset_n_i, mode_select_pin_i, secured_i, cpu_req_i, cpu_we_i, dbg_req_i;
  logic        mode_wr_i, mode_wdata_i, page_wr_i, cpu_gnt_o, dbg_gnt_o, mem_we_o, dbg_deny_o;
  logic        sys_reset_req_o, mode_o, background_debug_active_o;
  logic [15:0] cpu_addr_i, dbg_addr_i;
  logic [3:0]  page_wdata_i, page_o;
  logic [17:0] mem_addr_o;
  logic [2:0]  mem_tgt_o;
  int          failures, total_checks, w, wc;
  mmc_top i_dut (.*);
  mmc_masters i_m (.mclk_i(mclk_i), .cpu_gnt_i(cpu_gnt_o), .dbg_gnt_i(dbg_gnt_o),
    .cpu_req_o(cpu_req_i), .cpu_we_o(cpu_we_i), .cpu_addr_o(cpu_addr_i),
    .dbg_req_o(dbg_req_i), .dbg_addr_o(dbg_addr_i));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic step();
    @(posedge mclk_i);
    #5;
  endtask : step
  // Pin is set before reset so the synchroniser has settled at release
  task automatic do_reset(input logic pin);
    mode_select_pin_i = pin;
    reset_n_i = 1'b0;
    repeat (2) step();
    chk("mode_rst", mode_o, pin);
    reset_n_i = 1'b1;
    repeat (2) step();
  endtask : do_reset
  // Idle edge first, so a strobe is never raised in the step that lowered it
  task automatic acc(input bit dbg, input logic [15:0] addr, input logic we);
    step();
    i_m.go(dbg, addr, we, w);
    if (w == 99) begin
      failures++;
      stop_test();
    end
  endtask : acc
  task automatic wr_mode(input logic v);
    mode_wdata_i = v;
    mode_wr_i = 1'b1;
    step();
    mode_wr_i = 1'b0;
    step();
  endtask : wr_mode
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_mode();
    do_reset(1'b1);
    chk("mode", mode_o, 1);
    chk("bdm", background_debug_active_o, 1);
    chk("page", page_o, 18'he);
    wr_mode(1'b0);
    chk("mode", mode_o, 0);
    wr_mode(1'b1);
    chk("mode", mode_o, 0);
    do_reset(1'b0);
    chk("mode", mode_o, 0);
    chk("bdm", background_debug_active_o, 0);
  endtask : t_mode
  task automatic t_map();
    logic [15:0] la [8] = '{16'h0100, 16'h13ff, 16'h3100, 16'h5000,
                            16'h8123, 16'hc010, 16'hff10, 16'h0400};
    logic [2:0]  tg [8] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4, 3'h3};
    logic [17:0] ga [8] = '{18'h30100, 18'h313ff, 18'h33100, 18'h35000,
                            18'h38123, 18'h3c010, 18'h3ff10, 18'h30400};
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, la[i], i[0]);
      chk("tgt", mem_tgt_o, tg[i]);
      chk("addr", mem_addr_o, ga[i]);
      chk("we", mem_we_o, i[0]);
    end
    page_wdata_i = 4'h3;
    page_wr_i = 1'b1;
    step();
    page_wr_i = 1'b0;
    acc(1'b0, 16'h8123, 1'b0);
    chk("addr", mem_addr_o, 18'h0c123);
    acc(1'b0, 16'h1400, 1'b0);
    chk("sysrst", sys_reset_req_o, 1);
    step();
    chk("sysrst", sys_reset_req_o, 0);
  endtask : t_map
  task automatic t_arb();
    step();
    fork
      i_m.go(1'b1, 16'h3100, 1'b0, w);
      i_m.go(1'b0, 16'h0100, 1'b0, wc);
    join
    chk("dbgwait", w, 1);
    chk("cpuwait", wc, 2);
    chk("tgt", mem_tgt_o, 3'h1);
  endtask : t_arb
  task automatic t_secure();
    do_reset(1'b1);
    secured_i = 1'b1;
    wr_mode(1'b0);
    chk("mode", mode_o, 1);
    acc(1'b1, 16'h5000, 1'b0);
    chk("deny", dbg_deny_o, 1);
    acc(1'b1, 16'hff10, 1'b0);
    chk("tgt", mem_tgt_o, 3'h5);
    secured_i = 1'b0;
    acc(1'b1, 16'h5000, 1'b0);
    chk("deny", dbg_deny_o, 0);
  endtask : t_secure
  initial begin
    failures = 0;
    total_checks = 0;
    secured_i = 1'b0;
    mode_wr_i = 1'b0;
    mode_wdata_i = 1'b0;
    page_wr_i = 1'b0;
    page_wdata_i = 4'h0;
    t_mode();
    t_map();
    t_arb();
    t_secure();
    stop_test();
  end
endmodule : memory_mode_control_tb

/* dv/mmc_masters.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Processor and debug bus masters
// ----------------------------------------
module mmc_masters (
  input  wire logic        mclk_i,
  input  wire logic        cpu_gnt_i,
  input  wire logic        dbg_gnt_i,
  output logic             cpu_req_o,
  output logic             cpu_we_o,
  output logic [15:0]      cpu_addr_o,
  output logic             dbg_req_o,
  output logic [15:0]      dbg_addr_o
);
  initial begin
    cpu_req_o = 1'b0;
    cpu_we_o = 1'b0;
    cpu_addr_o = 16'h0000;
    dbg_req_o = 1'b0;
    dbg_addr_o = 16'h0000;
  end
  // Request held until grant at an edge; waits counts edges, 99 if not granted within 20 edges
  task automatic go(input bit dbg, input logic [15:0] addr, input logic we, output int waits);
    logic hit;
    waits = 0;
    if (dbg) begin
      dbg_addr_o = addr;
      dbg_req_o = 1'b1;
    end else begin
      cpu_addr_o = addr;
      cpu_we_o = we;
      cpu_req_o = 1'b1;
    end
    // Grant is sampled at mid-cycle, before edge updates can disturb it
    do begin
      @(negedge mclk_i);
      hit = dbg ? dbg_gnt_i : cpu_gnt_i;
      @(posedge mclk_i);
      waits++;
    end while (hit !== 1'b1 && waits < 20);
    #5;
    // Released address shows the inverse, never the stale value
    if (dbg) begin
      dbg_req_o = 1'b0;
      dbg_addr_o = ~addr;
    end else begin
      cpu_req_o = 1'b0;
      cpu_addr_o = ~addr;
    end
    if (hit !== 1'b1) waits = 99;
  endtask : go
endmodule : mmc_masters

/* dv/mmc_top_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checks for the map and mode unit
// ----------------------------------------
module mmc_chk (
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic        secured_i,
  input wire logic        cpu_req_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic        dbg_req_i,
  input wire logic [15:0] dbg_addr_i,
  input wire logic        mode_wr_i,
  input wire logic        cpu_gnt_o,
  input wire logic        dbg_gnt_o,
  input wire logic [17:0] mem_addr_o,
  input wire logic [2:0]  mem_tgt_o,
  input wire logic        dbg_deny_o,
  input wire logic        sys_reset_req_o,
  input wire logic        mode_o,
  input wire logic [3:0]  page_o,
  input wire logic        background_debug_active_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Steps shared by the properties: release and accepted requests
  sequence s_release; $rose(reset_n_i); endsequence
  sequence s_cpu_take; cpu_req_i && cpu_gnt_o; endsequence
  sequence s_dbg_take; dbg_req_i && dbg_gnt_o; endsequence
  property p_dbg_first; dbg_req_i |-> !cpu_gnt_o; endproperty
  property p_one_gnt; !(cpu_gnt_o && dbg_gnt_o); endproperty
  property p_unmapped;
    s_cpu_take ##0 (cpu_addr_i inside {[16'h1400:16'h2fff]}) |=> sys_reset_req_o;
  endproperty
  property p_reset_cause; sys_reset_req_o |-> $past(cpu_gnt_o); endproperty
  property p_paged;
    s_cpu_take ##0 (cpu_addr_i[15:14] == 2'h2)
      |=> mem_addr_o == {$past(page_o), $past(cpu_addr_i[13:0])};
  endproperty
  property p_top_page;
    s_cpu_take ##0 (cpu_addr_i[15:14] == 2'h3) |=> mem_addr_o[17:14] == 4'hf;
  endproperty
  property p_dbg_rom; s_dbg_take ##0 (dbg_addr_i >= 16'hff00) |=> mem_tgt_o == 3'h5; endproperty
  property p_deny;
    s_dbg_take ##0 (secured_i && dbg_addr_i inside {[16'h4000:16'hfeff]}) |=> dbg_deny_o;
  endproperty
  property p_secure_mode; secured_i && mode_wr_i |=> $stable(mode_o); endproperty
  property p_no_raise; !mode_o && mode_wr_i |=> !mode_o; endproperty
  property p_dbg_active; s_release |=> background_debug_active_o == mode_o; endproperty
  a_dbg_first: assert property (p_dbg_first) else $error("cpu granted over debug");
  a_one_gnt: assert property (p_one_gnt) else $error("two grants at once");
  a_unmapped: assert property (p_unmapped) else $error("no reset on unmapped");
  a_reset_cause: assert property (p_reset_cause) else $error("reset without access");
  a_paged: assert property (p_paged) else $error("paged address wrong");
  a_top_page: assert property (p_top_page) else $error("top page wrong");
  a_dbg_rom: assert property (p_dbg_rom) else $error("debug map wrong");
  a_deny: assert property (p_deny) else $error("secured flash not blocked");
  a_secure_mode: assert property (p_secure_mode) else $error("mode written secured");
  a_no_raise: assert property (p_no_raise) else $error("mode raised");
  a_dbg_active: assert property (p_dbg_active) else $error("debug state wrong");
endmodule : mmc_chk
bind mmc_top mmc_chk i_chk (.*);
